// >>> common/eprp_map.vh
/*
 File holds the timing counts and widths used by the EPROM programmer controller.
 Assumes it is included by bare name from design files clocked at 200 MHz.
*/
`ifndef EPRP_MAP_VH
`define EPRP_MAP_VH

// ----------------------------------------------------------------
// Clock and widths
// ----------------------------------------------------------------
`define EPRP_CLK_MHZ        200
`define EPRP_ADDR_W         17
`define EPRP_DATA_W         8
`define EPRP_ERASED_BYTE    8'hff

// ----------------------------------------------------------------
// Times in their own units and derived cycle counts
// ----------------------------------------------------------------
`define EPRP_PULSE_NOM_US   100
`define EPRP_PULSE_MIN_US   95
`define EPRP_PULSE_MAX_US   105
`define EPRP_SETUP_US       2
`define EPRP_HOLD_US        2
`define EPRP_ACCESS_NS      150
`define EPRP_FLOAT_NS       150
`define EPRP_SYNC_CYC       3
`define EPRP_PULSE_CYC      (`EPRP_PULSE_NOM_US * `EPRP_CLK_MHZ)
`define EPRP_SETUP_CYC      (`EPRP_SETUP_US * `EPRP_CLK_MHZ)
`define EPRP_HOLD_CYC       (`EPRP_HOLD_US * `EPRP_CLK_MHZ)
`define EPRP_ACCESS_CYC     ((`EPRP_ACCESS_NS * `EPRP_CLK_MHZ + 999) / 1000)
`define EPRP_FLOAT_CYC      ((`EPRP_FLOAT_NS * `EPRP_CLK_MHZ + 999) / 1000)
`define EPRP_RETRY_MAX      25

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define EPRP_CMD_READ       1'b0
`define EPRP_CMD_WRITE      1'b1

`endif

// >>> src/eprp_sync.v
/*
 File holds a three-stage input synchroniser with agreement filter per bit.
 Assumes inputs arrive from outside the ref_clk domain.
*/
`timescale 1ns/1ps

module eprp_sync #(
    parameter W = 8
) (
    input  wire         ref_clk, // System clock
    input  wire         rst,     // Asynchronous reset, active high
    input  wire [W-1:0] din,     // Raw pin levels
    output reg  [W-1:0] dout     // Filtered levels
);

    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;

    // ----------------------------------------------------------------
    // One agreement stage per bit
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    s1[i]   <= 1'b0;
                    s2[i]   <= 1'b0;
                    s3[i]   <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    s1[i] <= din[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        dout[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate

endmodule // eprp_sync

// >>> src/eprp_host.v
/*
 File holds the host-side controller that reads and programs a 128K x 8 EPROM
 through its pins: chip select, output gate, program strobe, supply switch,
 word select and byte lines.
 Assumes the supply switch is an external regulator and the byte lines resolve
 from the enable given here; the memory answers within the access time.
*/
// How it works
// - Raise program supply, select low to program
// - Present address and byte each write
// - Strobe pulse lasts 95 to 105 us
// - Never switch supply with select, strobe low
`timescale 1ns/1ps
`include "eprp_map.vh"

module eprp_host #(
    parameter AW        = `EPRP_ADDR_W,
    parameter DW        = `EPRP_DATA_W,
    parameter PULSE_CYC = `EPRP_PULSE_CYC,
    parameter SETUP_CYC = `EPRP_SETUP_CYC,
    parameter RETRY_MAX = `EPRP_RETRY_MAX
) (
    input  wire          ref_clk,            // System clock, 200 MHz
    input  wire          rst,                // Asynchronous reset, active high
    input  wire          req_valid,          // Request present
    output wire          req_ready,          // Controller idle, takes request
    input  wire          req_write,          // 1 program, 0 read
    input  wire [AW-1:0] req_addr,           // Word address
    input  wire [DW-1:0] req_data,           // Byte to program
    output reg           rsp_valid,          // One-cycle answer pulse
    output reg  [DW-1:0] rsp_data,           // Byte read or last verify byte
    output reg           rsp_fail,           // Program gave up: a one read back as zero, or retry limit
    output reg           chip_select_low,    // Chip select, active low
    output reg           output_gate_low,    // Output gate, active low
    output reg           program_strobe_low, // Program strobe, active low
    output reg           prog_supply_on,     // Program supply level requested
    output reg  [AW-1:0] word_select_lines,  // Address pins
    output reg  [DW-1:0] byte_lines_out,     // Byte lines drive value
    output reg           byte_lines_oe,      // Byte lines driven when high
    input  wire [DW-1:0] byte_lines_in       // Byte lines sampled value
);

    localparam CW = 16;
    localparam          ACC_I   = `EPRP_ACCESS_CYC + `EPRP_SYNC_CYC;
    localparam          FLT_I   = `EPRP_FLOAT_CYC;
    localparam [CW-1:0] ACC_CYC = ACC_I[CW-1:0];
    localparam [CW-1:0] FLT_CYC = FLT_I[CW-1:0];
    localparam [CW-1:0] PW_CYC  = PULSE_CYC[CW-1:0];
    localparam [CW-1:0] SU_CYC  = SETUP_CYC[CW-1:0];
    localparam [7:0]    RLIM    = RETRY_MAX[7:0];

    localparam [3:0] S_IDLE   = 4'h0;
    localparam [3:0] S_RD     = 4'h1;
    localparam [3:0] S_VUP    = 4'h2;
    localparam [3:0] S_PSET   = 4'h3;
    localparam [3:0] S_PULSE  = 4'h4;
    localparam [3:0] S_PHOLD  = 4'h5;
    localparam [3:0] S_FLOAT  = 4'h6;
    localparam [3:0] S_VFY    = 4'h7;
    localparam [3:0] S_VDOWN  = 4'h8;
    localparam [3:0] S_DONE   = 4'h9;

    reg  [3:0]    state;
    reg  [CW-1:0] cnt;
    reg  [7:0]    tries;
    reg  [DW-1:0] want;
    reg           fail;
    wire [DW-1:0] rd_byte;

    assign req_ready = (state == S_IDLE);

    // ----------------------------------------------------------------
    // Byte line input synchroniser
    // ----------------------------------------------------------------
    eprp_sync #(
        .W (DW)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (byte_lines_in),
        .dout    (rd_byte)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state              <= S_IDLE;
            cnt                <= 16'h0000;
            tries              <= 8'h00;
            want               <= `EPRP_ERASED_BYTE;
            fail               <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_data           <= `EPRP_ERASED_BYTE;
            rsp_fail           <= 1'b0;
            chip_select_low    <= 1'b1;
            output_gate_low    <= 1'b1;
            program_strobe_low <= 1'b1;
            prog_supply_on     <= 1'b0;
            word_select_lines  <= {AW{1'b0}};
            byte_lines_out     <= `EPRP_ERASED_BYTE;
            byte_lines_oe      <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
            S_IDLE: begin
                cnt <= 16'h0000;
                if (req_valid) begin
                    word_select_lines <= req_addr;
                    tries             <= 8'h00;
                    fail              <= 1'b0;
                    if (req_write == `EPRP_CMD_WRITE) begin
                        want  <= req_data;
                        state <= S_VUP;
                    end else begin
                        chip_select_low <= 1'b0;
                        output_gate_low <= 1'b0;
                        byte_lines_oe   <= 1'b0;
                        state           <= S_RD;
                    end
                end
            end
            S_RD: begin
                cnt <= cnt + 16'h0001;
                if (cnt == ACC_CYC) begin
                    rsp_data        <= rd_byte;
                    chip_select_low <= 1'b1;
                    output_gate_low <= 1'b1;
                    cnt             <= 16'h0000;
                    state           <= S_FLOAT;
                end
            end
            S_VUP: begin
                // Supply rises only while deselected
                prog_supply_on <= 1'b1;
                cnt            <= cnt + 16'h0001;
                if (cnt == SU_CYC) begin
                    chip_select_low <= 1'b0;
                    output_gate_low <= 1'b1;
                    byte_lines_out  <= want;
                    byte_lines_oe   <= 1'b1;
                    cnt             <= 16'h0000;
                    state           <= S_PSET;
                end
            end
            S_PSET: begin
                cnt <= cnt + 16'h0001;
                if (cnt == SU_CYC) begin
                    program_strobe_low <= 1'b0;
                    cnt                <= 16'h0000;
                    state              <= S_PULSE;
                end
            end
            S_PULSE: begin
                cnt <= cnt + 16'h0001;
                if (cnt == PW_CYC - 16'h0001) begin
                    program_strobe_low <= 1'b1;
                    tries              <= tries + 8'h01;
                    cnt                <= 16'h0000;
                    state              <= S_PHOLD;
                end
            end
            S_PHOLD: begin
                cnt <= cnt + 16'h0001;
                if (cnt == SU_CYC) begin
                    byte_lines_oe   <= 1'b0;
                    output_gate_low <= 1'b0;
                    cnt             <= 16'h0000;
                    state           <= S_VFY;
                end
            end
            S_VFY: begin
                cnt <= cnt + 16'h0001;
                if (cnt == ACC_CYC) begin
                    rsp_data        <= rd_byte;
                    output_gate_low <= 1'b1;
                    cnt             <= 16'h0000;
                    // A zero cannot become one again, so give up at once
                    if ((rd_byte & want) != want) begin
                        fail  <= 1'b1;
                        state <= S_VDOWN;
                    end else if (rd_byte == want) begin
                        state <= S_VDOWN;
                    end else if (tries >= RLIM) begin
                        fail  <= 1'b1;
                        state <= S_VDOWN;
                    end else begin
                        state <= S_FLOAT;
                    end
                end
            end
            S_FLOAT: begin
                // Byte lines released, wait for the memory to float
                cnt <= cnt + 16'h0001;
                if (cnt == FLT_CYC) begin
                    cnt <= 16'h0000;
                    if (prog_supply_on) begin
                        byte_lines_out <= want;
                        byte_lines_oe  <= 1'b1;
                        state          <= S_PSET;
                    end else begin
                        state <= S_DONE;
                    end
                end
            end
            S_VDOWN: begin
                // Deselect first, then drop supply: inhibit mode
                chip_select_low <= 1'b1;
                cnt             <= cnt + 16'h0001;
                if (cnt == SU_CYC) begin
                    prog_supply_on <= 1'b0;
                    cnt            <= 16'h0000;
                    state          <= S_DONE;
                end
            end
            S_DONE: begin
                rsp_valid <= 1'b1;
                rsp_fail  <= fail;
                state     <= S_IDLE;
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end

endmodule // eprp_host

// >>> verification/eprp_host_props.sv
/* Concurrent checks on the pin sequencing of eprp_host.
   Assumes a bind to eprp_host; sees only its ports. */
`timescale 1ns/1ps
module eprp_host_props #(
    parameter AW        = 17,
    parameter DW        = 8,
    parameter PULSE_CYC = 20000
) (
    input wire          ref_clk,            // Clock
    input wire          rst,                // Reset, active high
    input wire          req_valid,          // Request present
    input wire          req_ready,          // Idle
    input wire          req_write,          // Program request
    input wire          rsp_valid,          // Answer pulse
    input wire          chip_select_low,    // Select
    input wire          output_gate_low,    // Gate
    input wire          program_strobe_low, // Strobe
    input wire          prog_supply_on,     // Supply request
    input wire [AW-1:0] word_select_lines,  // Address
    input wire [DW-1:0] byte_lines_out,     // Drive value
    input wire          byte_lines_oe       // Drive enable
);
    reg [31:0] low_cnt;
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            low_cnt <= 32'h0;
        else if (!program_strobe_low)
            low_cnt <= low_cnt + 32'h1;
        else
            low_cnt <= 32'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_pulse_end; $rose(program_strobe_low); endsequence
    sequence s_verify; !chip_select_low && !output_gate_low && !byte_lines_oe; endsequence
    a_prog_entry:
        assert property (!program_strobe_low |-> prog_supply_on && !chip_select_low
            && output_gate_low) else $error("strobe low outside program mode");
    a_supply_steady:
        assert property ((!chip_select_low && !program_strobe_low) |-> $stable(prog_supply_on))
            else $error("supply moved during pulse");
    a_pulse_width:
        assert property (s_pulse_end |-> low_cnt == PULSE_CYC) else $error("pulse width wrong");
    a_data_steady:
        assert property (!program_strobe_low |-> byte_lines_oe && $stable(byte_lines_out)
            && $stable(word_select_lines)) else $error("address or data moved in pulse");
    a_data_hold:
        assert property (s_pulse_end |-> byte_lines_oe[*2]) else $error("data not held");
    a_verify_follows:
        assert property (s_pulse_end |-> ##[1:200] s_verify) else $error("no verify read");
    a_no_contention:
        assert property (byte_lines_oe |-> output_gate_low) else $error("drive with gate low");
    a_read_answer:
        assert property ((req_valid && req_ready && !req_write) |-> ##[1:200] rsp_valid)
            else $error("read not answered");
endmodule // eprp_host_props
bind eprp_host eprp_host_props #(.AW(AW), .DW(DW), .PULSE_CYC(PULSE_CYC)) i_props (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .rsp_valid(rsp_valid), .chip_select_low(chip_select_low),
    .output_gate_low(output_gate_low), .program_strobe_low(program_strobe_low),
    .prog_supply_on(prog_supply_on), .word_select_lines(word_select_lines),
    .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));

// >>> verification/eprp_dev_model.sv
/* Behavioural model of the 128K x 8 programmable memory at the pins.
   Assumes the bench resolves the byte lines and feeds them back here. */
`timescale 1ns/1ps
module eprp_dev_model #(
    parameter ACC_NS = 140
) (
    input  wire        chip_select_low,    // Select
    input  wire        output_gate_low,    // Gate
    input  wire        program_strobe_low, // Strobe
    input  wire        prog_supply_on,     // Program supply present
    input  wire [16:0] word_select_lines,  // Address
    input  wire [7:0]  byte_lines,         // Resolved lines
    output reg  [7:0]  dev_q,              // Drive value, junk when floating
    output wire        dev_oe              // Model drives the lines
);
    reg [7:0] mem [int];
    reg [7:0] junk = 8'h5a;
    int       stubborn = 0;
    function automatic [7:0] stored(input [16:0] a);
        stored = mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    // Released lines never keep the last value
    always #3 junk = ~junk;
    assign #(ACC_NS) dev_oe = !chip_select_low && !output_gate_low;
    always @(dev_oe or word_select_lines or junk) begin
        dev_q = dev_oe ? stored(word_select_lines) : junk;
    end
    // Weak cells ignore the first stubborn pulses
    always @(posedge program_strobe_low) begin
        if (!chip_select_low && output_gate_low && prog_supply_on) begin
            if (stubborn > 0)
                stubborn--;
            else
                mem[word_select_lines] = stored(word_select_lines) & byte_lines;
        end
    end
endmodule // eprp_dev_model

// >>> verification/test_eprp_host.sv
/* Self-checking bench for eprp_host against the memory model.
   Assumes shortened pulse and setup counts; inputs change on falling edges. */
`timescale 1ns/1ps
module test_eprp_host;
    reg         ref_clk = 1'b0;
    reg         rst = 1'b1;
    reg         req_valid = 1'b0;
    reg         req_write = 1'b0;
    reg  [16:0] req_addr = 17'h0;
    reg  [7:0]  req_data = 8'h0;
    wire        req_ready, rsp_valid, rsp_fail, cs_n, gate_n, pgm_n, vpp, oe, dev_oe;
    wire [7:0]  rsp_data, bl_out, bl_in, dev_q;
    wire [16:0] addr;
    integer     n_fail = 0;
    integer     n_tests = 0;
    integer     cyc = 0;
    assign bl_in = oe ? bl_out : dev_q;
    eprp_host #(.PULSE_CYC(20), .SETUP_CYC(4), .RETRY_MAX(3)) i_eprp_host (
        .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
        .chip_select_low(cs_n), .output_gate_low(gate_n), .program_strobe_low(pgm_n),
        .prog_supply_on(vpp), .word_select_lines(addr), .byte_lines_out(bl_out),
        .byte_lines_oe(oe), .byte_lines_in(bl_in));
    eprp_dev_model #(.ACC_NS(140)) i_eprp_dev_model (
        .chip_select_low(cs_n), .output_gate_low(gate_n), .program_strobe_low(pgm_n),
        .prog_supply_on(vpp), .word_select_lines(addr), .byte_lines(bl_in),
        .dev_q(dev_q), .dev_oe(dev_oe));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Host and memory must never drive the byte lines together
    always @(negedge ref_clk) begin
        if (oe === 1'b1)
            check1("byte line contention", 1'b0, dev_oe);
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check8(input string what, input [7:0] exp, input [7:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task check1(input string what, input exp, input got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task run_req(input w, input [16:0] a, input [7:0] d);
        integer i;
        @(negedge ref_clk);
        req_valid = 1'b1; req_write = w; req_addr = a; req_data = d;
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
        check1("rsp_valid", 1'b1, rsp_valid);
        check1("req_ready", 1'b1, req_ready);
        check1("supply off", 1'b0, vpp);
        check1("select idle", 1'b1, cs_n);
        check1("lines released", 1'b0, oe);
        @(negedge ref_clk);
        check1("rsp pulse", 1'b0, rsp_valid);
    endtask
    task t_erased;
        run_req(0, 17'h1ffff, 8'h00);
        check8("erased byte", 8'hff, rsp_data);
        $display("test erased read done");
    endtask
    task t_program;
        run_req(1, 17'h00123, 8'h5a);
        check1("program fail", 1'b0, rsp_fail);
        run_req(0, 17'h00123, 8'h00);
        check8("read back", 8'h5a, rsp_data);
        $display("test program done");
    endtask
    task t_retry;
        i_eprp_dev_model.stubborn = 2;
        run_req(1, 17'h00007, 8'h3c);
        check1("retry fail", 1'b0, rsp_fail);
        run_req(0, 17'h00007, 8'h00);
        check8("retry byte", 8'h3c, rsp_data);
        $display("test retry done");
    endtask
    task t_ones_lost;
        run_req(1, 17'h00123, 8'hf0);
        check1("ones lost fail", 1'b1, rsp_fail);
        run_req(0, 17'h00123, 8'h00);
        check8("ones lost byte", 8'h50, rsp_data);
        $display("test ones lost done");
    endtask
    task t_give_up;
        i_eprp_dev_model.stubborn = 10;
        run_req(1, 17'h0abcd, 8'h00);
        check1("give up fail", 1'b1, rsp_fail);
        i_eprp_dev_model.stubborn = 0;
        run_req(0, 17'h0abcd, 8'h00);
        check8("give up byte", 8'hff, rsp_data);
        $display("test give up done");
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        t_erased;
        t_program;
        t_retry;
        t_ones_lost;
        t_give_up;
        give_verdict;
    end
endmodule // test_eprp_host
